// file: bench/mmel_link_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module mmel_link_chk (
   input wire logic       clk_sys_i,
   input wire logic       rst_i,
   input wire logic       tx_ready_i,
   input wire logic [7:0] tx_data_o,
   input wire logic       tx_valid_o,
   input wire logic [4:0] chan_o,
   input wire logic       setup_exit_i,
   input wire logic       global_setup_selection_i,
   input wire logic [4:0] chan_sel_i,
   input wire logic [4:0] nv_chan_o,
   input wire logic       nv_chan_we_o,
   input wire logic [1:0] disp_msg_o,
   input wire logic       mem_busy_o,
   input wire logic       pgm_rx_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   property p_hold;
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
   endproperty
   a_hold: assert property (p_hold) else $error("tx byte dropped");
   property p_off;
      chan_o == 5'h00 && tx_valid_o |-> tx_data_o[7:4] != 4'h9 && tx_data_o[7:4] != 4'hC;
   endproperty
   a_off: assert property (p_off) else $error("sent while off");
   property p_chan;
      tx_valid_o && tx_data_o[7:4] == 4'h9 |-> tx_data_o[3:0] == chan_o[3:0] - 4'h1;
   endproperty
   a_chan: assert property (p_chan) else $error("wrong channel");
   property p_save;
      setup_exit_i && global_setup_selection_i |=> nv_chan_we_o
         && nv_chan_o == $past(chan_sel_i) && chan_o == $past(chan_sel_i) ##1 !nv_chan_we_o;
   endproperty
   a_save: assert property (p_save) else $error("channel not saved");
   property p_stor;
      $rose(nv_chan_we_o) |-> disp_msg_o == 2'h1;
   endproperty
   a_stor: assert property (p_stor) else $error("no storing shown");
   property p_load;
      disp_msg_o == 2'h3 |-> mem_busy_o;
   endproperty
   a_load: assert property (p_load) else $error("loading not busy");
   property p_dend;
      $fell(mem_busy_o) && $past(disp_msg_o) == 2'h2 |-> disp_msg_o == 2'h0;
   endproperty
   a_dend: assert property (p_dend) else $error("display not restored");
   property p_pgm;
      pgm_rx_o |=> !pgm_rx_o;
   endproperty
   a_pgm: assert property (p_pgm) else $error("long program pulse");
endmodule
bind mmel_link mmel_link_chk mmel_link_chk_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
   .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .chan_o(chan_o),
   .setup_exit_i(setup_exit_i), .global_setup_selection_i(global_setup_selection_i),
   .chan_sel_i(chan_sel_i), .nv_chan_o(nv_chan_o), .nv_chan_we_o(nv_chan_we_o),
   .disp_msg_o(disp_msg_o), .mem_busy_o(mem_busy_o), .pgm_rx_o(pgm_rx_o));
`default_nettype wire

// file: bench/mmel_seq_model.sv
`timescale 1ns/10ps
`default_nettype none
// Sequencer: records what it gets and never echoes it back.
module mmel_seq_model (
   input  wire logic       clk_sys_i,
   input  wire logic       stall_i,
   input  wire logic [7:0] tx_data_i,
   input  wire logic       tx_valid_i,
   output logic            tx_ready_o,
   output logic      [7:0] rx_data_o,
   output logic            rx_valid_o
);
   logic [7:0] got[$];
   initial
   begin
      rx_data_o  = 8'h00;
      rx_valid_o = 1'h0;
   end
   always @(posedge clk_sys_i)
      if (tx_valid_i && tx_ready_o)
         got.push_back(tx_data_i);
   always @(negedge clk_sys_i)
      tx_ready_o <= !stall_i;
   // Drives one given byte onto the receive lines for one cycle.
   task send(input logic [7:0] b);
      @(negedge clk_sys_i);
      rx_data_o  = b;
      rx_valid_o = 1'h1;
      @(negedge clk_sys_i);
      rx_valid_o = 1'h0;
      rx_data_o  = ~b;
   endtask
endmodule
`default_nettype wire

// file: bench/test_mmel_link.sv
`timescale 1ns/10ps
`default_nettype none
module test_mmel_link;
   logic clk_sys_i = 1'h0;
   logic rst_i = 1'h1;
   logic [111:0] sw = '0, em = '0, ms;
   logic sv = 1'h1, ld = 1'h1, vw = 1'h0, up = 1'h1, pl = 1'h0, gs = 1'h0, sx = 1'h0;
   logic pr = 1'h0, stall = 1'h0, ex = 1'h1, txv, txr, rxv, nvwe, prx, busy;
   logic [4:0] cs = 5'h01, nv = 5'h01, ch, nvc;
   logic [6:0] pn = 7'h05, prn;
   logic [7:0] txd, rxd, b;
   logic [1:0] disp;
   int errors = 0, compares = 0, cycles = 0;
   always #10 clk_sys_i = ~clk_sys_i;
   mmel_link #(.MEM_BYTES(16), .MSG_CYCLES(20)) mmel_link_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .mute_sw_i(sw), .expander_i(ex), .save_key_i(sv), .load_key_i(ld), .view_key_i(vw),
      .step_up_key_i(up), .play_key_i(pl), .global_setup_selection_i(gs), .setup_exit_i(sx),
      .chan_sel_i(cs), .nv_chan_i(nv), .pgm_tx_req_i(pr), .pgm_tx_num_i(pn), .rx_data_i(rxd),
      .rx_valid_i(rxv), .tx_ready_i(txr), .tx_data_o(txd), .tx_valid_o(txv), .mute_state_o(ms),
      .chan_o(ch), .nv_chan_o(nvc), .nv_chan_we_o(nvwe), .pgm_rx_o(prx), .pgm_rx_num_o(prn),
      .disp_msg_o(disp), .mem_busy_o(busy));
   mmel_seq_model seq_i (.clk_sys_i(clk_sys_i), .stall_i(stall), .tx_data_i(txd),
      .tx_valid_i(txv), .tx_ready_o(txr), .rx_data_o(rxd), .rx_valid_o(rxv));
   task give_verdict;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         give_verdict;
      end
   end
   task chk(input logic [63:0] g, input logic [63:0] e);
      compares++;
      if (g !== e)
      begin
         errors++;
         $display("mismatch at %0t got %0h exp %0h", $time, g, e);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   task take(input logic [7:0] e);
      int n;
      n = 0;
      while (seq_i.got.size() == 0 && n < 3000)
      begin
         cyc(1);
         n++;
      end
      b = (seq_i.got.size() > 0) ? seq_i.got.pop_front() : 8'hXX;
      chk(b, e);
   endtask
   task frame(input logic [6:0] n, input logic [6:0] v);
      take(8'h8F + nv);
      take({1'h0, n});
      take({1'h0, v});
   endtask
   task keys(input logic s, input logic l);
      sv = s;
      ld = l;
      cyc(4);
      vw = 1'h1;
      cyc(4);
      vw = 1'h0;
      sv = 1'h0;
      ld = 1'h0;
      cyc(4);
   endtask
   task wait_disp(input logic [1:0] v);
      int n;
      n = 0;
      while (disp !== v && n < 500)
      begin
         cyc(1);
         n++;
      end
   endtask
   task dump_chk(input logic [6:0] base, input logic [6:0] step);
      keys(1'h1, 1'h0);
      chk(disp, 2'h2);
      take(8'hF0);
      take(8'h7E);
      take(8'h7F);
      for (int i = 0; i < 16; i++)
         take({1'h0, base + step * i[6:0]});
      take(8'hF7);
      cyc(2);
      chk(disp, 2'h0);
      $display("dump test done");
   endtask
   task load(input logic [6:0] base, input logic cancel);
      keys(1'h0, 1'h1);
      chk(disp, 2'h3);
      if (cancel)
         keys(1'h0, 1'h1);
      else
      begin
         seq_i.send(8'hF0);
         seq_i.send(8'h01);
         seq_i.send(8'h02);
         for (int i = 0; i < 16; i++)
            seq_i.send({1'h0, base + i[6:0]});
         seq_i.send(8'hF7);
         cyc(2);
      end
      chk(disp, 2'h0);
      $display("load test done");
   endtask
   task t_erase;
      repeat (4) @(posedge clk_sys_i);
      @(negedge clk_sys_i) rst_i = 1'h0;
      wait_disp(2'h1);
      chk(disp, 2'h1);
      chk(ms[31:0], 32'h00000000);
      sv = 1'h0;
      ld = 1'h0;
      up = 1'h0;
      wait_disp(2'h0);
      dump_chk(7'h00, 7'h00);
   endtask
   task t_mute;
      stall = 1'h1;
      sw[5] = 1'h1;
      cyc(12);
      chk({seq_i.got.size(), txv, txd}, {32'h0, 9'h190});
      chk(ms[5], 1'h1);
      stall = 1'h0;
      frame(7'h05, 7'h01);
      sw[100] = 1'h1;
      frame(7'h64, 7'h01);
      sw[5] = 1'h0;
      frame(7'h05, 7'h7F);
      em[100] = 1'h1;
      $display("mute test done");
   endtask
   task t_rx;
      logic [87:0] m;
      m = 88'h900A010B3F910C01907001;
      for (int i = 10; i >= 0; i--)
         seq_i.send(m[i*8+:8]);
      cyc(2);
      em[11:10] = 2'h3;
      chk({ms[111:96], ms[15:0]}, {em[111:96], em[15:0]});
      $display("receive test done");
   endtask
   task t_play;
      pl = 1'h1;
      for (int n = 0; n < 112; n++)
         frame(n[6:0], em[n] ? 7'h01 : 7'h7F);
      pl = 1'h0;
      $display("play test done");
   endtask
   task t_pgm;
      int n;
      pn = 7'h3A;
      pr = 1'h1;
      cyc(1);
      pr = 1'h0;
      take(8'hC0);
      take(8'h3A);
      seq_i.send(8'hC0);
      seq_i.send(8'h07);
      n = 0;
      while (prx !== 1'h1 && n < 10)
      begin
         cyc(1);
         n++;
      end
      chk({prx, prn}, 8'h87);
      $display("program test done");
   endtask
   task t_off;
      cs = 5'h00;
      gs = 1'h1;
      sx = 1'h1;
      cyc(1);
      sx = 1'h0;
      chk({ch, nvc, disp}, 12'h001);
      cyc(25);
      chk(disp, 2'h0);
      sw[6] = 1'h1;
      pr = 1'h1;
      cyc(1);
      pr = 1'h0;
      pl = 1'h1;
      seq_i.send(8'h90);
      seq_i.send(8'h0C);
      seq_i.send(8'h01);
      cyc(40);
      chk({seq_i.got.size(), ms[12], ms[6]}, 34'h1);
      pl = 1'h0;
      cs = 5'h01;
      sx = 1'h1;
      cyc(1);
      sx = 1'h0;
      gs = 1'h0;
      cyc(30);
      chk({ch, seq_i.got.size()}, 37'h01_0000_0000);
      $display("channel off test done");
   endtask
   task t_base;
      rst_i = 1'h1;
      ex = 1'h0;
      nv = 5'h03;
      cyc(2);
      rst_i = 1'h0;
      cyc(8);
      sw[70] = 1'h1;
      sw[7] = 1'h1;
      frame(7'h07, 7'h01);
      cyc(8);
      chk({ch, ms[70], seq_i.got.size()}, {5'h03, 33'h0});
      $display("restart test done");
   endtask
   initial
   begin
      t_erase;
      load(7'h20, 1'h0);
      dump_chk(7'h20, 7'h01);
      load(7'h20, 1'h1);
      dump_chk(7'h20, 7'h01);
      t_mute;
      t_rx;
      t_play;
      t_pgm;
      t_off;
      t_base;
      give_verdict;
   end
endmodule
`default_nettype wire

// file: logic/mmel_link.sv
// Contract
// - Muting sends note-on velocity 1, unmuting sends velocity 127.
// - Each mute switch has a fixed note: 0-63, or 0-111 with expander.
// - Received note-on on our channel sets that note's mute state.
// - Pressing play sends a note-on burst of every current mute state.
// - Mute notes and program changes use only the shared channel.
// - Channel is off or 1-16; off blocks all note and program traffic.
// - Leaving global setup saves the channel and briefly shows storing.
// - Save held plus view-select sends whole memory as bulk dump, shows saving.
// - Load held plus view-select shows loading, waits, overwrites memory.
// - Repeating load plus view-select while waiting cancels, memory untouched.
// - Save, load, step-up held at power-on erase memory and show storing.
`timescale 1ns/10ps
`default_nettype none

module mmel_link #(
   parameter int MEM_BYTES  = mmel_pkg::MEM_BYTES,
   parameter int MSG_CYCLES = mmel_pkg::MSG_CYCLES
) (
   input  wire logic         clk_sys_i,
   input  wire logic         rst_i,
   input  wire logic [111:0] mute_sw_i,
   input  wire logic         expander_i,
   input  wire logic         save_key_i,
   input  wire logic         load_key_i,
   input  wire logic         view_key_i,
   input  wire logic         step_up_key_i,
   input  wire logic         play_key_i,
   input  wire logic         global_setup_selection_i,
   input  wire logic         setup_exit_i,
   input  wire logic [4:0]   chan_sel_i,
   input  wire logic [4:0]   nv_chan_i,
   input  wire logic         pgm_tx_req_i,
   input  wire logic [6:0]   pgm_tx_num_i,
   input  wire logic [7:0]   rx_data_i,
   input  wire logic         rx_valid_i,
   input  wire logic         tx_ready_i,
   output logic      [7:0]   tx_data_o,
   output logic              tx_valid_o,
   output logic      [111:0] mute_state_o,
   output logic      [4:0]   chan_o,
   output logic      [4:0]   nv_chan_o,
   output logic              nv_chan_we_o,
   output logic              pgm_rx_o,
   output logic      [6:0]   pgm_rx_num_o,
   output logic      [1:0]   disp_msg_o,
   output logic              mem_busy_o
);

   localparam int AW    = $clog2(MEM_BYTES);
   localparam int MSG_W = $clog2(MSG_CYCLES + 1);
   localparam logic [AW:0] LAST_ADDR = (AW + 1)'(MEM_BYTES - 1);

   typedef struct packed {
      mmel_pkg::mmel_state_t st;
      logic [2:0]            phase;
      logic [AW:0]           cnt;
      logic [AW-1:0]         maddr;
      logic                  mem_we;
      logic [6:0]            mem_wdata;
      logic                  rd_ok;
      logic                  erasing;
      logic [6:0]            note;
      logic                  muted;
      logic [7:0]            tx_data;
      logic                  tx_valid;
      logic [4:0]            chan;
      logic [4:0]            nv_chan;
      logic                  nv_we;
      logic                  expn;
      logic [111:0]          mute;
      logic [111:0]          sw_seen;
      logic [111:0]          sw1;
      logic [111:0]          sw2;
      logic [4:0]            key1;
      logic [4:0]            key2;
      logic [4:0]            key3;
      logic                  exp1;
      logic                  exp2;
      logic [7:0]            rx_status;
      logic                  rx_half;
      logic [6:0]            rx_d1;
      logic                  pgm_rx;
      logic [6:0]            pgm_rx_num;
      logic                  pgm_pend;
      logic [6:0]            pgm_tx_num;
      logic [1:0]            msg;
      logic [MSG_W-1:0]      msg_cnt;
      logic [2:0]            init_cnt;
   } mmel_regs_t;

   mmel_regs_t s;
   mmel_regs_t next_s;
   logic [6:0] mem_rdata;

   ////////////////////////////////////////////////////////////////////////////////

   // Builds byte i of a note-on frame for the given channel and state.
   function automatic logic [7:0] note_byte(input logic [1:0] i,
                                            input logic [4:0] ch,
                                            input logic [6:0] nt,
                                            input logic       m);
      logic [4:0] c1;
      c1 = ch - mmel_pkg::CHAN_ONE;
      if (i == 2'h0)
         note_byte = {mmel_pkg::STATUS_NOTE_ON, c1[3:0]};
      else if (i == 2'h1)
         note_byte = {1'b0, nt};
      else
         note_byte = {1'b0, m ? mmel_pkg::VEL_MUTED : mmel_pkg::VEL_UNMUTED};
   endfunction

   // Finds the lowest set bit of a vector, reporting whether one exists.
   function automatic logic [7:0] first_set(input logic [111:0] v);
      first_set = 8'h00;
      for (int i = mmel_pkg::NUM_NOTES - 1; i >= 0; i--)
      begin
         if (v[i])
            first_set = {1'b1, 7'(i)};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////

   logic [4:0]   keys;
   logic         view_rise;
   logic         play_rise;
   logic         tx_free;
   logic         chan_on;
   logic [6:0]   last_note;
   logic [111:0] note_mask;
   logic [111:0] sw_change;
   logic [7:0]   sw_first;
   logic [4:0]   chan_m1;
   logic         chan_match;

   always_comb
   begin
      keys       = {play_key_i, step_up_key_i, view_key_i, load_key_i, save_key_i};
      view_rise  = s.key2[mmel_pkg::KEY_VIEW] & ~s.key3[mmel_pkg::KEY_VIEW];
      play_rise  = s.key2[mmel_pkg::KEY_PLAY] & ~s.key3[mmel_pkg::KEY_PLAY];
      tx_free    = ~s.tx_valid | tx_ready_i;
      chan_on    = s.chan != mmel_pkg::CHAN_OFF;
      last_note  = s.expn ? mmel_pkg::LAST_NOTE_EXP : mmel_pkg::LAST_NOTE_BASE;
      for (int i = 0; i < mmel_pkg::NUM_NOTES; i++)
         note_mask[i] = 7'(i) <= last_note;
      sw_change  = (s.sw2 ^ s.sw_seen) & note_mask;
      sw_first   = first_set(sw_change);
      chan_m1    = s.chan - mmel_pkg::CHAN_ONE;
      chan_match = chan_on && s.rx_status[3:0] == chan_m1[3:0];
   end

   ////////////////////////////////////////////////////////////////////////////////

   always_comb
   begin
      next_s        = s;
      next_s.sw1    = mute_sw_i;
      next_s.sw2    = s.sw1;
      next_s.key1   = keys;
      next_s.key2   = s.key1;
      next_s.key3   = s.key2;
      next_s.exp1   = expander_i;
      next_s.exp2   = s.exp1;
      next_s.nv_we  = 1'b0;
      next_s.pgm_rx = 1'b0;
      next_s.mem_we = 1'b0;
      if (s.tx_valid && tx_ready_i)
         next_s.tx_valid = 1'b0;

      // Brief message timer; long operations hold their own message.
      if (s.msg == mmel_pkg::MSG_STORING)
      begin
         if (s.msg_cnt == '0)
            next_s.msg = mmel_pkg::MSG_NONE;
         else
            next_s.msg_cnt = s.msg_cnt - 1'b1;
      end

      if (global_setup_selection_i && setup_exit_i)
      begin
         next_s.chan    = chan_sel_i;
         next_s.nv_chan = chan_sel_i;
         next_s.nv_we   = 1'b1;
         next_s.msg     = mmel_pkg::MSG_STORING;
         next_s.msg_cnt = MSG_W'(MSG_CYCLES - 1);
      end

      if (pgm_tx_req_i)
      begin
         next_s.pgm_pend   = chan_on;
         next_s.pgm_tx_num = pgm_tx_num_i;
      end

      // Receive parser for note-on and program change, idle while loading.
      if (rx_valid_i && s.st != mmel_pkg::ST_LOAD)
      begin
         if (rx_data_i[7])
         begin
            if (rx_data_i < mmel_pkg::SYSEX_START)
            begin
               next_s.rx_status = rx_data_i;
               next_s.rx_half   = 1'b0;
            end
            else if (rx_data_i < mmel_pkg::REALTIME_FIRST)
               next_s.rx_status = 8'h00;
         end
         else if (chan_match && s.rx_status[7:4] == mmel_pkg::STATUS_NOTE_ON)
         begin
            if (!s.rx_half)
            begin
               next_s.rx_d1   = rx_data_i[6:0];
               next_s.rx_half = 1'b1;
            end
            else
            begin
               next_s.rx_half = 1'b0;
               if (s.rx_d1 <= last_note && rx_data_i[6:0] != 7'h00)
                  next_s.mute[s.rx_d1] = rx_data_i[6:0] < mmel_pkg::VEL_MUTE_LIMIT;
            end
         end
         else if (chan_match && s.rx_status[7:4] == mmel_pkg::STATUS_PGM)
         begin
            next_s.pgm_rx     = 1'b1;
            next_s.pgm_rx_num = rx_data_i[6:0];
         end
      end

      unique case (s.st)
         mmel_pkg::ST_INIT:
         begin
            next_s.init_cnt = s.init_cnt + 3'h1;
            if (s.init_cnt == mmel_pkg::INIT_WAIT)
            begin
               next_s.expn    = s.exp2;
               next_s.chan    = nv_chan_i;
               next_s.nv_chan = nv_chan_i;
               next_s.sw_seen = s.sw2;
               next_s.mute    = s.sw2;
               next_s.st      = mmel_pkg::ST_IDLE;
               if (s.key2[mmel_pkg::KEY_SAVE] && s.key2[mmel_pkg::KEY_LOAD] &&
                   s.key2[mmel_pkg::KEY_UP])
               begin
                  next_s.erasing = 1'b1;
                  next_s.cnt     = '0;
                  next_s.mute    = '0;
                  next_s.st      = mmel_pkg::ST_LOAD;
               end
            end
         end

         mmel_pkg::ST_IDLE:
         begin
            if (s.key2[mmel_pkg::KEY_SAVE] && view_rise)
            begin
               next_s.st    = mmel_pkg::ST_DUMP;
               next_s.phase = 3'h0;
               next_s.cnt   = '0;
               next_s.maddr = '0;
               next_s.rd_ok = 1'b0;
               next_s.msg   = mmel_pkg::MSG_SAVING;
            end
            else if (s.key2[mmel_pkg::KEY_LOAD] && view_rise)
            begin
               next_s.st    = mmel_pkg::ST_LOAD;
               next_s.phase = 3'h0;
               next_s.cnt   = '0;
               next_s.msg   = mmel_pkg::MSG_LOADING;
            end
            else if (play_rise && chan_on)
            begin
               next_s.st    = mmel_pkg::ST_BURST;
               next_s.note  = 7'h00;
               next_s.phase = 3'h0;
            end
            else if (s.pgm_pend)
            begin
               next_s.pgm_pend = 1'b0;
               next_s.phase    = 3'h0;
               next_s.st       = mmel_pkg::ST_PGM;
            end
            else if (sw_first[7])
            begin
               next_s.sw_seen[sw_first[6:0]] = s.sw2[sw_first[6:0]];
               next_s.mute[sw_first[6:0]]    = s.sw2[sw_first[6:0]];
               next_s.note  = sw_first[6:0];
               next_s.muted = s.sw2[sw_first[6:0]];
               next_s.phase = 3'h0;
               if (chan_on)
                  next_s.st = mmel_pkg::ST_NOTE;
            end
         end

         mmel_pkg::ST_NOTE:
         begin
            if (tx_free)
            begin
               next_s.tx_valid = 1'b1;
               next_s.tx_data  = note_byte(s.phase[1:0], s.chan, s.note, s.muted);
               next_s.phase    = s.phase + 3'h1;
               if (s.phase == 3'h2)
                  next_s.st = mmel_pkg::ST_IDLE;
            end
         end

         mmel_pkg::ST_BURST:
         begin
            if (tx_free)
            begin
               next_s.tx_valid = 1'b1;
               next_s.tx_data  = note_byte(s.phase[1:0], s.chan, s.note, s.mute[s.note]);
               next_s.phase    = s.phase + 3'h1;
               if (s.phase == 3'h2)
               begin
                  next_s.phase = 3'h0;
                  next_s.note  = s.note + 7'h01;
                  if (s.note == last_note)
                     next_s.st = mmel_pkg::ST_IDLE;
               end
            end
         end

         mmel_pkg::ST_PGM:
         begin
            if (tx_free)
            begin
               next_s.tx_valid = 1'b1;
               next_s.tx_data  = (s.phase == 3'h0) ? {mmel_pkg::STATUS_PGM, chan_m1[3:0]}
                                                   : {1'b0, s.pgm_tx_num};
               next_s.phase    = s.phase + 3'h1;
               if (s.phase == 3'h1)
                  next_s.st = mmel_pkg::ST_IDLE;
            end
         end

         mmel_pkg::ST_DUMP:
         begin
            if (s.phase < 3'h3)
            begin
               if (tx_free)
               begin
                  next_s.tx_valid = 1'b1;
                  next_s.tx_data  = (s.phase == 3'h0) ? mmel_pkg::SYSEX_START :
                                    (s.phase == 3'h1) ? mmel_pkg::SYSEX_UNIVERSAL
                                                      : mmel_pkg::SYSEX_ALL_DEV;
                  next_s.phase    = s.phase + 3'h1;
               end
            end
            else if (s.phase == 3'h3)
            begin
               if (!s.rd_ok)
                  next_s.rd_ok = 1'b1;
               else if (tx_free)
               begin
                  next_s.tx_valid = 1'b1;
                  next_s.tx_data  = {1'b0, mem_rdata};
                  next_s.rd_ok    = 1'b0;
                  next_s.cnt      = s.cnt + 1'b1;
                  next_s.maddr    = s.maddr + 1'b1;
                  if (s.cnt == LAST_ADDR)
                     next_s.phase = 3'h4;
               end
            end
            else if (tx_free)
            begin
               next_s.tx_valid = 1'b1;
               next_s.tx_data  = mmel_pkg::SYSEX_END;
               next_s.msg      = mmel_pkg::MSG_NONE;
               next_s.st       = mmel_pkg::ST_IDLE;
            end
         end

         mmel_pkg::ST_LOAD:
         begin
            if (s.erasing)
            begin
               next_s.mem_we    = 1'b1;
               next_s.mem_wdata = 7'h00;
               next_s.maddr     = s.cnt[AW-1:0];
               next_s.cnt       = s.cnt + 1'b1;
               if (s.cnt == LAST_ADDR)
               begin
                  next_s.erasing = 1'b0;
                  next_s.msg     = mmel_pkg::MSG_STORING;
                  next_s.msg_cnt = MSG_W'(MSG_CYCLES - 1);
                  next_s.st      = mmel_pkg::ST_IDLE;
               end
            end
            else if (s.key2[mmel_pkg::KEY_LOAD] && view_rise)
            begin
               next_s.msg = mmel_pkg::MSG_NONE;
               next_s.st  = mmel_pkg::ST_IDLE;
            end
            else if (rx_valid_i)
            begin
               if (rx_data_i == mmel_pkg::SYSEX_START)
               begin
                  next_s.phase = 3'h1;
                  next_s.cnt   = '0;
               end
               else if (rx_data_i == mmel_pkg::SYSEX_END && s.phase == 3'h3)
               begin
                  next_s.msg = mmel_pkg::MSG_NONE;
                  next_s.st  = mmel_pkg::ST_IDLE;
               end
               else if (!rx_data_i[7] && (s.phase == 3'h1 || s.phase == 3'h2))
                  next_s.phase = s.phase + 3'h1;
               else if (!rx_data_i[7] && s.phase == 3'h3 && !s.cnt[AW])
               begin
                  next_s.mem_we    = 1'b1;
                  next_s.mem_wdata = rx_data_i[6:0];
                  next_s.maddr     = s.cnt[AW-1:0];
                  next_s.cnt       = s.cnt + 1'b1;
               end
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s    <= '0;
         s.st <= mmel_pkg::ST_INIT;
      end
      else
      begin
         s <= next_s;
      end
   end

   mmel_store #(
      .DEPTH (MEM_BYTES),
      .AW    (AW)
   ) u_store (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .we_i      (s.mem_we),
      .addr_i    (s.maddr),
      .wdata_i   (s.mem_wdata),
      .rdata_o   (mem_rdata)
   );

   assign tx_data_o    = s.tx_data;
   assign tx_valid_o   = s.tx_valid;
   assign mute_state_o = s.mute;
   assign chan_o       = s.chan;
   assign nv_chan_o    = s.nv_chan;
   assign nv_chan_we_o = s.nv_we;
   assign pgm_rx_o     = s.pgm_rx;
   assign pgm_rx_num_o = s.pgm_rx_num;
   assign disp_msg_o   = s.msg;
   assign mem_busy_o   = s.st == mmel_pkg::ST_DUMP || s.st == mmel_pkg::ST_LOAD;

endmodule

`default_nettype wire

// file: logic/mmel_pkg.sv
`default_nettype none

package mmel_pkg;

   // Clock rate and the time that a brief panel message stays up.
   localparam int CLK_HZ      = 50_000_000;
   localparam int MSG_TIME_MS = 500;
   localparam int MSG_CYCLES  = CLK_HZ / 1000 * MSG_TIME_MS;

   // Cycles after reset release before straps and held keys are read.
   localparam logic [2:0] INIT_WAIT = 3'h4;

   // Note numbering.
   localparam int         NUM_NOTES      = 112;
   localparam logic [6:0] LAST_NOTE_BASE = 7'h3F;
   localparam logic [6:0] LAST_NOTE_EXP  = 7'h6F;

   // Message bytes.
   localparam logic [3:0] STATUS_NOTE_ON  = 4'h9;
   localparam logic [3:0] STATUS_PGM      = 4'hC;
   localparam logic [6:0] VEL_MUTED       = 7'h01;
   localparam logic [6:0] VEL_UNMUTED     = 7'h7F;
   localparam logic [6:0] VEL_MUTE_LIMIT  = 7'h40;
   localparam logic [7:0] SYSEX_START     = 8'hF0;
   localparam logic [7:0] SYSEX_UNIVERSAL = 8'h7E;
   localparam logic [7:0] SYSEX_ALL_DEV   = 8'h7F;
   localparam logic [7:0] SYSEX_END       = 8'hF7;
   localparam logic [7:0] REALTIME_FIRST  = 8'hF8;

   // Channel setting: zero is off, one to sixteen select a channel.
   localparam logic [4:0] CHAN_OFF = 5'h00;
   localparam logic [4:0] CHAN_ONE = 5'h01;

   // Stored memory size.
   localparam int MEM_BYTES = 16384;

   // Key positions in the synchronised key vector.
   localparam int KEY_SAVE  = 0;
   localparam int KEY_LOAD  = 1;
   localparam int KEY_VIEW  = 2;
   localparam int KEY_UP    = 3;
   localparam int KEY_PLAY  = 4;
   localparam int NUM_KEYS  = 5;

   // Panel message codes.
   localparam logic [1:0] MSG_NONE    = 2'h0;
   localparam logic [1:0] MSG_STORING = 2'h1;
   localparam logic [1:0] MSG_SAVING  = 2'h2;
   localparam logic [1:0] MSG_LOADING = 2'h3;

   typedef enum logic [6:0] {
      ST_INIT  = 7'h01,
      ST_IDLE  = 7'h02,
      ST_NOTE  = 7'h04,
      ST_BURST = 7'h08,
      ST_PGM   = 7'h10,
      ST_DUMP  = 7'h20,
      ST_LOAD  = 7'h40
   } mmel_state_t;

endpackage

`default_nettype wire

// file: logic/mmel_store.sv
`timescale 1ns/10ps
`default_nettype none

// Byte memory holding snapshots and setups, registered read data.
module mmel_store #(
   parameter int DEPTH = 16384,
   parameter int AW    = 14
) (
   input  wire logic          clk_sys_i,
   input  wire logic          rst_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] addr_i,
   input  wire logic [6:0]    wdata_i,
   output logic      [6:0]    rdata_o
);

   logic [6:0] mem [DEPTH];

   always_ff @(posedge clk_sys_i)
   begin
      if (we_i)
      begin
         mem[addr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rdata_o <= 7'h00;
      end
      else
      begin
         rdata_o <= mem[addr_i];
      end
   end

endmodule

`default_nettype wire
